// ---- logic/clcd_top.sv ----
// Lock-state controller, signal detect, ppm check and deserializer with APB
`timescale 1ns/1ps
module clcd_top
  import clcd_pkg::*;
#(
  parameter int ADDR_W     = 12,
  parameter int PPM_WINDOW = PPM_WINDOW_RST,
  parameter int CNT_W      = 12
) (
  input  wire logic              sys_clk,     // System clock, 100 MHz
  input  wire logic              rst_n,       // Async reset, active low
  input  wire logic [ADDR_W-1:0] paddr,       // APB address
  input  wire logic              psel,        // APB select
  input  wire logic              penable,     // APB enable
  input  wire logic              pwrite,      // APB direction
  input  wire logic [31:0]       pwdata,      // APB write data
  output logic      [31:0]       prdata,      // APB read data
  output logic                   pready,      // APB ready
  output logic                   pslverr,     // APB error on unmapped address
  input  wire logic              refTogA,     // Toggle from first PLL reference
  input  wire logic              refTogB,     // Toggle from second PLL reference
  input  wire logic              recTog,      // Toggle from recovered clock
  input  wire logic              levelHigh,   // Input level above upper threshold
  input  wire logic              levelLow,    // Input level below lower threshold
  input  wire logic              forceRef,    // Fabric request for reference lock
  input  wire logic              forceData,   // Fabric request for data lock
  input  wire logic [1:0]        serPair,     // Two serial samples per clock
  output logic                   phaseDetEn,  // Phase detector enable
  output logic                   freqLocked,  // Frequency locked
  output logic                   sigPresent,  // Signal present
  output logic      [9:0]        parWord,     // Word to the word aligner
  output logic                   parValid,    // Word strobe
  output logic                   irq          // Level interrupt
);

  //----------------------------------------------------------------------------
  // Declarations
  //----------------------------------------------------------------------------
  localparam int NSYNC = 5;

  logic [CTRL_W-1:0] ctrl;
  logic [CNT_W-1:0]  ppmThr;
  logic [EV_W-1:0]   intStat;
  logic [EV_W-1:0]   intMask;
  logic [EV_W-1:0]   events;
  logic [9:0]        rxWord;
  logic              wordFresh;

  logic [NSYNC-1:0]  asyncIn;
  logic [NSYNC-1:0]  syncS1;
  logic [NSYNC-1:0]  syncS2;
  logic [NSYNC-1:0]  syncS3;
  logic [NSYNC-1:0]  syncOut;

  logic              refLevel;
  logic              refLevelD;
  logic              recLevelD;
  logic              refEdge;
  logic              recEdge;
  logic [CNT_W-1:0]  refCnt;
  logic [CNT_W-1:0]  recCnt;
  logic [CNT_W-1:0]  cntDiff;
  logic              inRange;

  logic              sigRaw;
  logic [7:0]        sigFilt;
  logic              sigDet;
  logic              next_sigPresent;

  clcd_state_t       state;
  clcd_state_t       next_state;
  clcd_state_t       autoNext;

  logic              setup;
  logic              access;
  logic              wrEn;
  logic              rdEn;
  logic              mapped;
  logic [31:0]       rdMux;
  logic [9:0]        deserWord;
  logic              deserValid;

  //----------------------------------------------------------------------------
  // Pin synchronisers: a change counts once stages two and three agree
  //----------------------------------------------------------------------------
  assign asyncIn = {levelLow, levelHigh, recTog, refTogB, refTogA};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          syncS1[gi]  <= 1'b0;
          syncS2[gi]  <= 1'b0;
          syncS3[gi]  <= 1'b0;
          syncOut[gi] <= 1'b0;
        end else begin
          syncS1[gi] <= asyncIn[gi];
          syncS2[gi] <= syncS1[gi];
          syncS3[gi] <= syncS2[gi];
          if (syncS2[gi] == syncS3[gi]) begin
            syncOut[gi] <= syncS3[gi];
          end
        end
      end
    end
  endgenerate

  //----------------------------------------------------------------------------
  // Frequency check: recovered edges against selected reference edges
  //----------------------------------------------------------------------------
  assign refLevel = ctrl[CTRL_REF_SEL] ? syncOut[1] : syncOut[0];
  assign refEdge  = refLevel ^ refLevelD;
  assign recEdge  = syncOut[2] ^ recLevelD;
  assign cntDiff  = (recCnt > refCnt) ? (recCnt - refCnt) : (refCnt - recCnt);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      refLevelD <= 1'b0;
      recLevelD <= 1'b0;
    end else begin
      refLevelD <= refLevel;
      recLevelD <= syncOut[2];
    end
  end

  // A window closes after a fixed number of reference edges
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      refCnt  <= '0;
      recCnt  <= '0;
      inRange <= 1'b0;
    end else if (ctrl[CTRL_LOCK_RST]) begin
      refCnt  <= '0;
      recCnt  <= '0;
      inRange <= 1'b0;
    end else if (refEdge && (refCnt == CNT_W'(PPM_WINDOW - 1))) begin
      inRange <= (cntDiff <= ppmThr);
      refCnt  <= '0;
      recCnt  <= CNT_W'(recEdge);
    end else begin
      refCnt <= refCnt + CNT_W'(refEdge);
      recCnt <= recCnt + CNT_W'(recEdge);
    end
  end

  //----------------------------------------------------------------------------
  // Signal detect with hysteresis and ringing filter
  //----------------------------------------------------------------------------
  // Sets above the upper threshold, clears only below the lower one
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sigRaw <= 1'b0;
    end else if (syncOut[3]) begin
      sigRaw <= 1'b1;
    end else if (syncOut[4]) begin
      sigRaw <= 1'b0;
    end
  end

  // Must hold steady for the filter time before the output follows
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sigFilt <= 8'h00;
      sigDet  <= 1'b0;
    end else if (sigRaw == sigDet) begin
      sigFilt <= 8'h00;
    end else if (sigFilt == 8'(SIG_FILT_CYC - 1)) begin
      sigFilt <= 8'h00;
      sigDet  <= sigRaw;
    end else begin
      sigFilt <= sigFilt + 8'h01;
    end
  end

  assign next_sigPresent = ctrl[CTRL_CODEC_EN] ? sigDet : 1'b1;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sigPresent <= 1'b1;
    end else begin
      sigPresent <= next_sigPresent;
    end
  end

  //----------------------------------------------------------------------------
  // Lock-state controller
  //----------------------------------------------------------------------------
  always_comb begin
    autoNext = state;
    case (state)
      ST_REF_LOCK: begin
        if (inRange && (!ctrl[CTRL_PIPE] || sigPresent)) begin
          autoNext = ST_DATA_LOCK;
        end
      end
      ST_DATA_LOCK: begin
        if (!inRange || (ctrl[CTRL_PIPE] && !sigPresent)) begin
          autoNext = ST_REF_LOCK;
        end
      end
      default: begin
        autoNext = ST_REF_LOCK;
      end
    endcase
  end

  always_comb begin
    if (ctrl[CTRL_LOCK_RST]) begin
      next_state = ST_REF_LOCK;
    end else if (ctrl[CTRL_FORCE_EN] && forceRef) begin
      next_state = ST_REF_LOCK;
    end else if (ctrl[CTRL_FORCE_EN] && forceData) begin
      next_state = ST_DATA_LOCK;
    end else begin
      next_state = autoNext;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_REF_LOCK;
    end else begin
      state <= next_state;
    end
  end

  // Outputs follow the state in the same cycle it is entered
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phaseDetEn <= 1'b0;
      freqLocked <= 1'b0;
    end else begin
      phaseDetEn <= (next_state == ST_DATA_LOCK);
      freqLocked <= (next_state == ST_DATA_LOCK);
    end
  end

  //----------------------------------------------------------------------------
  // Deserializer; words only leave while tracking data
  //----------------------------------------------------------------------------
  clcd_deser u_deser (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .serPair  (serPair),
    .width10  (ctrl[CTRL_WIDTH10]),
    .enable   (phaseDetEn),
    .parWord  (deserWord),
    .parValid (deserValid)
  );

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      parWord  <= 10'h000;
      parValid <= 1'b0;
    end else begin
      parWord  <= deserWord;
      parValid <= deserValid;
    end
  end

  //----------------------------------------------------------------------------
  // Events and interrupt
  //----------------------------------------------------------------------------
  assign events[EV_LOCK_GAIN] = (state == ST_REF_LOCK) && (next_state == ST_DATA_LOCK);
  assign events[EV_LOCK_LOSS] = (state == ST_DATA_LOCK) && (next_state == ST_REF_LOCK);
  assign events[EV_SIG_GAIN]  = !sigPresent && next_sigPresent;
  assign events[EV_SIG_LOSS]  = sigPresent && !next_sigPresent;
  assign events[EV_WORD]      = deserValid;

  // A new event in the clearing cycle stays set
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      intStat <= '0;
    end else if (wrEn && (paddr == ADDR_W'(OFS_INT_STAT))) begin
      intStat <= (intStat & ~pwdata[EV_W-1:0]) | events;
    end else begin
      intStat <= intStat | events;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(intStat & intMask);
    end
  end

  //----------------------------------------------------------------------------
  // Received word capture, fresh flag cleared by reading it
  //----------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rxWord    <= 10'h000;
      wordFresh <= 1'b0;
    end else if (deserValid) begin
      rxWord    <= deserWord;
      wordFresh <= 1'b1;
    end else if (rdEn && (paddr == ADDR_W'(OFS_RX_WORD))) begin
      wordFresh <= 1'b0;
    end
  end

  //----------------------------------------------------------------------------
  // APB slave: no wait states, answer in the first access cycle
  //----------------------------------------------------------------------------
  assign setup  = psel && !penable;
  assign access = psel && penable && pready;
  assign wrEn   = access && pwrite;
  assign rdEn   = access && !pwrite;

  always_comb begin
    mapped = 1'b1;
    rdMux  = 32'h0000_0000;
    if (paddr == ADDR_W'(OFS_CTRL)) begin
      rdMux[CTRL_W-1:0] = ctrl;
    end else if (paddr == ADDR_W'(OFS_STATUS)) begin
      rdMux[5:0] = {wordFresh, inRange, sigPresent, freqLocked, phaseDetEn, state};
    end else if (paddr == ADDR_W'(OFS_INT_STAT)) begin
      rdMux[EV_W-1:0] = intStat;
    end else if (paddr == ADDR_W'(OFS_INT_MASK)) begin
      rdMux[EV_W-1:0] = intMask;
    end else if (paddr == ADDR_W'(OFS_RX_WORD)) begin
      rdMux[9:0] = rxWord;
    end else if (paddr == ADDR_W'(OFS_PPM_THR)) begin
      rdMux[CNT_W-1:0] = ppmThr;
    end else begin
      mapped = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup && !mapped;
      if (setup && !pwrite) begin
        prdata <= rdMux;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl    <= CTRL_RST;
      intMask <= '0;
      ppmThr  <= CNT_W'(PPM_THR_RST);
    end else if (wrEn) begin
      if (paddr == ADDR_W'(OFS_CTRL)) begin
        ctrl <= pwdata[CTRL_W-1:0];
      end else if (paddr == ADDR_W'(OFS_INT_MASK)) begin
        intMask <= pwdata[EV_W-1:0];
      end else if (paddr == ADDR_W'(OFS_PPM_THR)) begin
        ppmThr <= pwdata[CNT_W-1:0];
      end
    end
  end

endmodule : clcd_top

// ---- logic/clcd_pkg.sv ----
// Constants, register map and types for the lock controller and deserializer
//------------------------------------------------------------------------------
// Function
// - Power-up and every reset put the clock recovery unit in reference lock.
// - Reference lock disables the phase detector; serial data cannot move phase.
// - Data lock enables the phase detector so it tracks data for best phase.
// - Auto mode enters data lock on ppm in range, plus signal present in PIPE.
// - Auto mode leaves data lock on ppm out of range or PIPE signal loss.
// - Outside PIPE mode automatic transitions ignore signal present.
// - Auto mode: frequency lock rises entering data lock, falls leaving it.
// - Manual mode sets state from force inputs; fabric drives those inputs.
// - Manual mode: frequency lock high in data lock, low in reference lock.
// - Without the force enable the controller runs in automatic mode.
// - Signal present follows the level detector with hysteresis against ringing.
// - Detection only with the 8B/10B block enabled; otherwise signal present high.
// - Independent recovery per channel; reference chosen from two adjacent PLLs.
// - Fast recovered clock drives deserializer; slow cadence drives coding blocks.
// - Serial bits assemble into an 8- or 10-bit word, first bit is LSB.
// - Half-rate clock: two bits captured per clock, one per edge.
// - The parallel word feeds the downstream word aligner.
//------------------------------------------------------------------------------
package clcd_pkg;

  //----------------------------------------------------------------------------
  // Register byte offsets
  //----------------------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL     = 12'h000;
  localparam logic [11:0] OFS_STATUS   = 12'h004;
  localparam logic [11:0] OFS_INT_STAT = 12'h008;
  localparam logic [11:0] OFS_INT_MASK = 12'h00C;
  localparam logic [11:0] OFS_RX_WORD  = 12'h010;
  localparam logic [11:0] OFS_PPM_THR  = 12'h014;

  //----------------------------------------------------------------------------
  // Control field positions and reset values
  //----------------------------------------------------------------------------
  localparam int CTRL_LOCK_RST = 0;
  localparam int CTRL_PIPE     = 1;
  localparam int CTRL_CODEC_EN = 2;
  localparam int CTRL_FORCE_EN = 3;
  localparam int CTRL_REF_SEL  = 4;
  localparam int CTRL_WIDTH10  = 5;
  localparam int CTRL_W        = 6;
  localparam logic [5:0]  CTRL_RST    = 6'h20;
  localparam logic [11:0] PPM_THR_RST = 12'h0004;

  //----------------------------------------------------------------------------
  // Interrupt event bit positions
  //----------------------------------------------------------------------------
  localparam int EV_LOCK_GAIN = 0;
  localparam int EV_LOCK_LOSS = 1;
  localparam int EV_SIG_GAIN  = 2;
  localparam int EV_SIG_LOSS  = 3;
  localparam int EV_WORD      = 4;
  localparam int EV_W         = 5;

  //----------------------------------------------------------------------------
  // Timing
  //----------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 10;
  localparam int SIG_FILT_NS    = 100;
  localparam int SIG_FILT_CYC   = (SIG_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PPM_WINDOW_RST = 1024;
  localparam int WORD10_PAIRS   = 5;
  localparam int WORD8_PAIRS    = 4;

  //----------------------------------------------------------------------------
  // Types
  //----------------------------------------------------------------------------
  typedef enum logic [0:0] {
    ST_REF_LOCK  = 1'b0,
    ST_DATA_LOCK = 1'b1
  } clcd_state_t;

endpackage : clcd_pkg

// ---- logic/clcd_deser.sv ----
// Half-rate serial-to-parallel converter, 8- or 10-bit words, LSB first
`timescale 1ns/1ps
module clcd_deser
  import clcd_pkg::*;
(
  input  wire logic       sys_clk,  // Fast recovered clock, half bit rate
  input  wire logic       rst_n,    // Async reset, active low
  input  wire logic [1:0] serPair,  // Bit 0 rising-edge sample, bit 1 falling
  input  wire logic       width10,  // High: 10-bit words, low: 8-bit
  input  wire logic       enable,   // Word output allowed
  output logic      [9:0] parWord,  // Assembled word
  output logic            parValid  // One-cycle word strobe
);

  logic [9:0] shiftReg;
  logic [2:0] pairCnt;
  logic [2:0] lastPair;

  assign lastPair = width10 ? 3'(WORD10_PAIRS - 1) : 3'(WORD8_PAIRS - 1);

  //----------------------------------------------------------------------------
  // Shift in two bits per clock; earliest bit ends in bit 0
  //----------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      shiftReg <= 10'h000;
    end else if (width10) begin
      shiftReg <= {serPair[1], serPair[0], shiftReg[9:2]};
    end else begin
      shiftReg <= {2'b00, serPair[1], serPair[0], shiftReg[7:2]};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pairCnt <= 3'h0;
    end else if (pairCnt >= lastPair) begin
      pairCnt <= 3'h0;
    end else begin
      pairCnt <= pairCnt + 3'h1;
    end
  end

  //----------------------------------------------------------------------------
  // Word strobe marks the slow cadence for the coding layer
  //----------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      parWord  <= 10'h000;
      parValid <= 1'b0;
    end else begin
      parValid <= enable && (pairCnt == lastPair);
      if (pairCnt == lastPair) begin
        if (width10) begin
          parWord <= {serPair[1], serPair[0], shiftReg[9:2]};
        end else begin
          parWord <= {2'b00, serPair[1], serPair[0], shiftReg[7:2]};
        end
      end
    end
  end

endmodule : clcd_deser

// ---- test/clcd_asserts.sv ----
// Port-level checks for the lock controller and deserializer
`timescale 1ns/1ps
module clcd_top_asserts #(
  parameter int ADDR_W = 12
) (
  input wire logic              sys_clk,    // Clock
  input wire logic              rst_n,      // Reset, active low
  input wire logic [ADDR_W-1:0] paddr,      // APB address
  input wire logic              psel,       // APB select
  input wire logic              penable,    // APB enable
  input wire logic              pready,     // APB ready
  input wire logic              pslverr,    // APB error
  input wire logic              phaseDetEn, // Phase detector enable
  input wire logic              freqLocked, // Frequency locked
  input wire logic              sigPresent, // Signal present
  input wire logic              parValid    // Word strobe
);
  //--------------------
  // Properties
  //--------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_quiet;
    !parValid [*3];
  endsequence
  a_ready_next: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  a_ready_only: assert property (pready |-> psel && penable && $past(psel && !penable))
    else $error("ready outside access");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_unmapped_err: assert property (psel && !penable && paddr > 20 |=> pslverr)
    else $error("unmapped not refused");
  a_lock_pair: assert property (phaseDetEn == freqLocked)
    else $error("lock flag differs from detector");
  a_reset_ref: assert property ($rose(rst_n) |-> !phaseDetEn [*8])
    else $error("not in reference lock after reset");
  a_word_lock: assert property (parValid |-> $past(phaseDetEn, 2))
    else $error("word in reference lock");
  a_word_gap: assert property (parValid |=> s_quiet)
    else $error("words too close");
  a_sig_hold: assert property ($changed(sigPresent) |=> $stable(sigPresent) [*8])
    else $error("signal present toggles fast");
endmodule : clcd_top_asserts

bind clcd_top clcd_top_asserts #(.ADDR_W(ADDR_W)) u_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .paddr(paddr), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .phaseDetEn(phaseDetEn), .freqLocked(freqLocked), .sigPresent(sigPresent), .parValid(parValid));

// ---- test/clcd_tx_model.sv ----
// Remote serial transmitter model, two bits per clock
`timescale 1ns/1ps
module clcd_tx_model (
  input  wire logic       sys_clk, // Clock
  input  wire logic       rst_n,   // Reset, active low
  input  wire logic       txOn,    // Transmitter active
  input  wire logic       slow,    // Slower link clock
  input  wire logic       wide,    // High: 10-bit words
  input  wire logic [9:0] txWord,  // Next word
  output logic      [1:0] serPair, // Bit pair, earlier bit in bit 0
  output logic            recTog   // Toggle per link clock
);
  //--------------------
  // Serializer
  //--------------------
  logic [9:0] shift;
  logic [2:0] left;
  logic [1:0] div;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      serPair <= 2'b01;
      shift   <= '0;
      left    <= '0;
    end else if (!txOn) begin
      serPair <= ~serPair; // Idle line keeps changing
    end else if (left == 3'd0) begin
      serPair <= txWord[1:0];
      shift   <= txWord >> 2;
      left    <= wide ? 3'd4 : 3'd3;
    end else begin
      serPair <= shift[1:0];
      shift   <= shift >> 2;
      left    <= left - 3'd1;
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div    <= '0;
      recTog <= 1'b0;
    end else if (txOn) begin
      div    <= (div == (slow ? 2'd2 : 2'd1)) ? 2'd0 : div + 2'd1;
      recTog <= (div == 2'd0) ? ~recTog : recTog;
    end
  end
endmodule : clcd_tx_model

// ---- test/clcd_tb_top.sv ----
// Self-checking bench for the lock controller and deserializer
`timescale 1ns/1ps
module clcd_tb_top;
  import clcd_pkg::*;
  //--------------------
  // Stimulus and checks
  //--------------------
  logic sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic refTogA = 0, refTogB = 0, levelHigh = 0, levelLow = 1, forceRef = 0, forceData = 0;
  logic txOn = 0, slow = 0, w10 = 1, chkOn = 0, recTog, irq;
  logic pready, pslverr, phaseDetEn, freqLocked, sigPresent, parValid;
  logic [11:0] paddr = '0, hist = '0;
  logic [31:0] pwdata = '0, prdata, rd, cyc = '0, seed = 32'h0315_218b;
  logic [1:0] serPair;
  logic [9:0] parWord, txWord = '0;
  int badCount = 0, testsRun = 0, nw = 0;

  clcd_top #(.PPM_WINDOW(16)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .refTogA(refTogA), .refTogB(refTogB), .recTog(recTog), .levelHigh(levelHigh),
    .levelLow(levelLow), .forceRef(forceRef), .forceData(forceData), .serPair(serPair),
    .phaseDetEn(phaseDetEn), .freqLocked(freqLocked), .sigPresent(sigPresent), .parWord(parWord),
    .parValid(parValid), .irq(irq));
  clcd_tx_model u_tx (.sys_clk(sys_clk), .rst_n(rst_n), .txOn(txOn), .slow(slow), .wide(w10),
    .txWord(txWord), .serPair(serPair), .recTog(recTog));

  always #5 sys_clk = ~sys_clk;

  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction : xs

  function automatic logic [9:0] expw(input logic [11:0] h, input logic wide);
    logic [9:0] r;
    int n;
    r = '0;
    n = wide ? 5 : 4;
    for (int i = 0; i < n; i++) r[2*i +: 2] = h[2*(n-i)+1 -: 2];
    return r;
  endfunction : expw

  function automatic logic pick(input int s);
    return s == 0 ? phaseDetEn : (s == 1 ? sigPresent : irq);
  endfunction : pick

  task automatic finalReport();
    $display("Comparisons %0d, mismatches %0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finalReport

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    testsRun++;
    if (got !== exp) begin
      badCount++;
      $display("CHECK FAILED at %0t: %s", $time, m);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge sys_clk); k++; end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin chk(0, 1, "bus timeout"); finalReport(); end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic waitfor(input int s, input logic v, input int lim, input string m);
    int k;
    for (k = 0; k < lim; k++) begin
      @(posedge sys_clk);
      if (pick(s) === v) break;
    end
    chk(32'(pick(s)), 32'(v), m);
    if (k >= lim) finalReport();
  endtask : waitfor

  // References: A every 2 cycles, B every 3; new random word each cycle
  always @(posedge sys_clk) begin
    cyc     <= cyc + 1;
    refTogA <= cyc[0] ? ~refTogA : refTogA;
    refTogB <= (cyc % 3 == 0) ? ~refTogB : refTogB;
    seed    <= xs(seed);
    txWord  <= seed[9:0];
    if (chkOn && parValid === 1'b1) begin
      nw++;
      chk(32'(parWord), 32'(expw(hist, w10)), "word");
    end
    hist <= {hist[9:0], serPair};
  end

  initial begin
    logic e;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    chk(32'({phaseDetEn, freqLocked, sigPresent}), 32'h1, "reset outputs");
    apb(0, OFS_CTRL, 0); chk(rd, 32'(CTRL_RST), "ctrl reset");
    apb(0, OFS_PPM_THR, 0); chk(rd, 32'(PPM_THR_RST), "threshold reset");
    apb(0, 12'h020, 0); chk(32'(err), 1, "unmapped");
    forceData <= 1'b1;
    repeat (20) @(posedge sys_clk);
    chk(32'(phaseDetEn), 0, "force ignored");
    apb(1, OFS_CTRL, 32'h0000_0028);
    for (int i = 0; i < 12; i++) begin
      e = seed[21] & ~seed[20];
      forceRef <= seed[20]; forceData <= seed[21];
      repeat (2) @(posedge sys_clk);
      chk(32'({phaseDetEn, freqLocked}), e ? 32'h3 : 32'h0, "manual state");
    end
    forceRef <= 1'b1; forceData <= 1'b0;
    apb(1, OFS_INT_MASK, 0); apb(1, OFS_INT_STAT, 32'h0000_001f);
    forceRef <= 1'b0; forceData <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk(32'(irq), 0, "masked event");
    apb(1, OFS_INT_MASK, 1); waitfor(2, 1, 4, "irq raised");
    apb(0, OFS_INT_STAT, 0); chk(rd & 32'h1, 1, "gain event");
    apb(1, OFS_INT_STAT, 1); waitfor(2, 0, 4, "irq cleared");
    chkOn <= 1'b1; txOn <= 1'b1;
    repeat (60) @(posedge sys_clk);
    chkOn <= 1'b0; w10 <= 1'b0;
    apb(1, OFS_CTRL, 32'h0000_0008);
    repeat (12) @(posedge sys_clk);
    chkOn <= 1'b1;
    repeat (60) @(posedge sys_clk);
    chk(32'(nw >= 20), 1, "words seen");
    forceRef <= 1'b1;
    repeat (4) @(posedge sys_clk);
    nw = 0;
    repeat (40) @(posedge sys_clk);
    chk(nw, 0, "words in reference lock");
    chkOn <= 1'b0; w10 <= 1'b1; forceRef <= 1'b0;
    apb(1, OFS_CTRL, 32'h0000_0024);
    waitfor(1, 0, 60, "signal absent");
    waitfor(0, 1, 300, "auto lock");
    slow <= 1'b1; waitfor(0, 0, 300, "rate lost");
    slow <= 1'b0; waitfor(0, 1, 300, "relock");
    apb(1, OFS_CTRL, 32'h0000_0034); waitfor(0, 0, 300, "second reference");
    apb(1, OFS_CTRL, 32'h0000_0026);
    repeat (150) @(posedge sys_clk);
    chk(32'(phaseDetEn), 0, "pipe waits for signal");
    levelLow <= 1'b0; levelHigh <= 1'b1;
    waitfor(1, 1, 60, "signal present");
    waitfor(0, 1, 300, "pipe lock");
    levelHigh <= 1'b0; levelLow <= 1'b1;
    waitfor(0, 0, 60, "pipe signal loss");
    finalReport();
  end
endmodule : clcd_tb_top
